// ---- hw/shift_latch.sv ----
`timescale 1ns/1ps
`include "shift_latch_params.svh"
// What this block does
// - Each shift clock rise moves the eight-stage chain, stage zero takes serial input.
// - Each rise loads last stage and rise serial output from prior seventh stage.
// - Fall serial output copies the rise serial output on the following fall.
// - On a fall, chain, latch and rise serial output hold.
// - Strobe high makes the latch transparent, following every shift.
// - Strobe low holds the latch; serial outputs keep updating.
// - Shift clock and transfer strobe act independently.
// - Output enable high drives the latch onto all parallel outputs.
// - Output enable low floats parallel outputs; serial outputs stay driven.
// - Output enable changes never alter chain or latch contents.
module shift_latch (
   clk,
   rst,
   host_pins,
   par_pins,
   serial_pins,
   shift_ready,
   word_data,
   word_valid,
   word_ready
);
   import shift_latch_pkg::*;

   input wire logic clk;
   input wire logic rst;
   input shift_latch_pkg::host_pins_t host_pins;
   output shift_latch_pkg::par_pins_t par_pins;
   output shift_latch_pkg::serial_pins_t serial_pins;
   output logic shift_ready;
   output shift_latch_pkg::word_t word_data;
   output logic word_valid;
   input wire logic word_ready;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: three stages, a level is accepted once stages two and three agree

   logic [`PIN_COUNT-1:0] sync_reg [`SYNC_STAGES];
   logic [`PIN_COUNT-1:0] level_reg;
   logic [`PIN_COUNT-1:0] level_next;

   always_ff @(posedge clk) begin
      if (rst) begin
         for (int s = 0; s < `SYNC_STAGES; s++) begin
            sync_reg[s] <= '0;
         end
      end else begin
         sync_reg[0] <= host_pins;
         for (int s = 1; s < `SYNC_STAGES; s++) begin
            sync_reg[s] <= sync_reg[s-1];
         end
      end
   end

   // Filtered level; only stages two and three are read
   function automatic logic settle(input logic s2, input logic s3, input logic cur);
      settle = (s2 == s3) ? s3 : cur;
   endfunction

   genvar g;
   generate
      for (g = 0; g < `PIN_COUNT; g++) begin : g_settle
         assign level_next[g] = settle(sync_reg[1][g], sync_reg[2][g], level_reg[g]);
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (rst) begin
         level_reg <= '0;
      end else begin
         level_reg <= level_next;
      end
   end

   logic clk_lvl;
   logic clk_lvl_next;
   logic strobe_lvl;
   logic oe_lvl;
   logic data_lvl;
   logic rise_evt;
   logic fall_evt;

   assign clk_lvl = level_reg[`PIN_SHIFT_CLOCK];
   assign clk_lvl_next = level_next[`PIN_SHIFT_CLOCK];
   assign strobe_lvl = level_reg[`PIN_TRANSFER_STROBE];
   assign oe_lvl = level_reg[`PIN_OUTPUT_ENABLE];
   // Data is taken at its settled level, so it must meet setup before the edge settles
   assign data_lvl = level_reg[`PIN_SERIAL_IN];
   assign rise_evt = clk_lvl_next && !clk_lvl;
   assign fall_evt = !clk_lvl_next && clk_lvl;

   ////////////////////////////////////////////////////////////////////////////////
   // Shift chain

   word_t chain_reg;
   word_t chain_next;

   always_comb begin
      chain_next = chain_reg;
      if (rise_evt) begin
         chain_next = {chain_reg[`CHAIN_LAST-1:0], data_lvl};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         chain_reg <= `CHAIN_RESET;
      end else begin
         chain_reg <= chain_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Serial cascade outputs

   logic rise_out_reg;
   logic fall_out_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         rise_out_reg <= 1'b0;
      end else if (rise_evt) begin
         rise_out_reg <= chain_reg[`RISE_TAP];
      end
   end

   // Half-cycle delayed copy for slow-edge cascading
   always_ff @(posedge clk) begin
      if (rst) begin
         fall_out_reg <= 1'b0;
      end else if (fall_evt) begin
         fall_out_reg <= chain_reg[`CHAIN_LAST];
      end
   end

   assign serial_pins.rise_serial_output = rise_out_reg;
   assign serial_pins.fall_serial_output = fall_out_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Storage latch, level-sensitive on the strobe; independent of the shift clock

   word_t latch_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         latch_reg <= `LATCH_RESET;
      end else if (strobe_lvl) begin
         latch_reg <= chain_next;
      end
   end // Strobe low holds output enable has no path here

   ////////////////////////////////////////////////////////////////////////////////
   // Three-state parallel outputs

   par_pins_t par_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         par_reg <= '{data: `LATCH_RESET, enable_n: 1'b1};
      end else begin
         par_reg.data <= strobe_lvl ? chain_next : latch_reg;
         par_reg.enable_n <= !oe_lvl;
      end
   end

   assign par_pins = par_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Word stream: every shift seen through an open latch is queued for the receiver.
   // The host must watch shift_ready; a shift while it is low loses that word.

   logic push_valid;

   assign push_valid = rise_evt && strobe_lvl;

   word_buffer #(
      .WIDTH(`CHAIN_WIDTH),
      .DEPTH(`WORD_BUF_DEPTH)
   ) u_word_buffer (
      .clk(clk),
      .rst(rst),
      .in_data(chain_next),
      .in_valid(push_valid),
      .in_ready(shift_ready),
      .out_data(word_data),
      .out_valid(word_valid),
      .out_ready(word_ready)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_SHIFT_MOVE: assert property (
      rise_evt |=> chain_reg == {$past(chain_reg[6:0]), $past(data_lvl)})
      else $error("chain did not shift on a rising edge");

   AST_RISE_TAP: assert property (
      rise_evt |=> rise_out_reg == $past(chain_reg[6]) && chain_reg[7] == $past(chain_reg[6]))
      else $error("rise output or last stage not loaded from stage seven");

   AST_FALL_COPY: assert property (
      rise_evt ##1 (!fall_evt && !rise_evt) [*1] ##0 1'b1 ##[0:400] fall_evt |=>
      fall_out_reg == rise_out_reg)
      else $error("fall output is not the half-cycle copy");

   AST_FALL_HOLDS: assert property (
      fall_evt && !strobe_lvl |=> $stable(chain_reg) && $stable(rise_out_reg) && $stable(latch_reg))
      else $error("falling edge disturbed chain, latch or rise output");

   AST_TRANSPARENT: assert property (
      strobe_lvl |=> latch_reg == chain_reg)
      else $error("open latch does not follow the chain");

   AST_HOLD_CLOSED: assert property (
      !strobe_lvl [*2] |=> $stable(par_reg.data))
      else $error("parallel data moved with the strobe low");

   AST_DRIVE: assert property (
      oe_lvl && !strobe_lvl |=> !par_pins.enable_n && par_pins.data == latch_reg)
      else $error("enabled outputs do not show the latch");

   AST_FLOAT: assert property (
      !oe_lvl |=> par_pins.enable_n)
      else $error("outputs driven with enable low");

   AST_OE_NO_EFFECT: assert property (
      $changed(oe_lvl) && !strobe_lvl && !rise_evt |=> $stable(latch_reg) && $stable(chain_reg))
      else $error("output enable altered stored state");

endmodule

// ---- hw/shift_latch_params.svh ----
`ifndef SHIFT_LATCH_PARAMS_SVH
`define SHIFT_LATCH_PARAMS_SVH

// Shift chain and storage latch geometry
`define CHAIN_WIDTH 8
`define CHAIN_LAST 7
`define RISE_TAP 6

// Pin bundle field positions
`define PIN_SERIAL_IN 3
`define PIN_SHIFT_CLOCK 2
`define PIN_TRANSFER_STROBE 1
`define PIN_OUTPUT_ENABLE 0
`define PIN_COUNT 4

// Reset values
`define CHAIN_RESET 8'h00
`define LATCH_RESET 8'h00

// Input synchroniser depth and word buffer depth
`define SYNC_STAGES 3
`define WORD_BUF_DEPTH 2

`endif

// ---- hw/shift_latch_pkg.sv ----
package shift_latch_pkg;

   typedef logic [7:0] word_t;

   // Control pins driven by the host or upstream stage
   typedef struct packed {
      logic serial_in;
      logic shift_clock;
      logic transfer_strobe;
      logic output_enable;
   } host_pins_t;

   // Three-state parallel output: enable_n low while driving
   typedef struct packed {
      word_t data;
      logic enable_n;
   } par_pins_t;

   // Serial cascade outputs
   typedef struct packed {
      logic rise_serial_output;
      logic fall_serial_output;
   } serial_pins_t;

endpackage

// ---- hw/word_buffer.sv ----
`timescale 1ns/1ps
module word_buffer #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] rd_ptr_reg;
   logic [CW-1:0] count_reg;
   logic push;
   logic pop;

   assign in_ready = (count_reg != CW'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign out_data = mem[rd_ptr_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= bump(wr_ptr_reg);
         end
         if (pop) begin
            rd_ptr_reg <= bump(rd_ptr_reg);
         end
         count_reg <= count_reg + CW'(push) - CW'(pop);
      end
   end

   AST_BUF_NO_OVERFLOW: assert property (@(posedge clk) disable iff (rst)
      (count_reg == CW'(DEPTH)) && !out_ready |=> !in_ready)
      else $error("word buffer accepted a word while full");

   AST_BUF_HOLDS_HEAD: assert property (@(posedge clk) disable iff (rst)
      out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("buffer head changed while stalled");

endmodule

// ---- sim/host_model.sv ----
`timescale 1ns/1ps
module host_model (
   input wire logic clk,
   output shift_latch_pkg::host_pins_t pins
);
   import shift_latch_pkg::*;

   // Every pin change lands 1 ns after a clock edge and holds 6 cycles,
   // well past the design's input filter
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Serial data is set up 6 cycles before the rise and held until the next bit
   task automatic shift_bit(input logic b);
      pins.serial_in = b;
      idle(6);
      pins.shift_clock = 1'b1;
      idle(6);
   endtask

   task automatic fall_edge();
      pins.shift_clock = 1'b0;
      idle(6);
   endtask

   task automatic set_ctl(input logic strobe, input logic oe);
      pins.transfer_strobe = strobe;
      pins.output_enable = oe;
      idle(6);
   endtask

   initial begin
      pins = '0;
   end
endmodule

// ---- sim/tb.sv ----
`timescale 1ns/1ps
module tb;
   import shift_latch_pkg::*;
   logic clk;
   logic rst;
   logic word_ready;
   host_pins_t host_pins;
   par_pins_t par_pins;
   serial_pins_t serial_pins;
   logic shift_ready;
   word_t word_data;
   logic word_valid;
   wire [7:0] par_bus;
   word_t chain;
   word_t latch;
   logic fall_exp;
   word_t q[$];
   int failures;
   int compares;

   // Three-state outputs resolved here
   assign par_bus = par_pins.enable_n ? 8'hZZ : par_pins.data;

   host_model host_model_inst (.clk(clk), .pins(host_pins));
   shift_latch shift_latch_inst (.clk(clk), .rst(rst), .host_pins(host_pins), .par_pins(par_pins),
      .serial_pins(serial_pins), .shift_ready(shift_ready), .word_data(word_data),
      .word_valid(word_valid), .word_ready(word_ready));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic end_sim();
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   function automatic logic [7:0] exp_bus();
      return host_pins.output_enable ? latch : 8'hZZ;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   task automatic ctl(input logic s, input logic oe);
      host_model_inst.set_ctl(s, oe);
      if (s) begin
         latch = chain;
      end
      chk8(par_bus, exp_bus());
   endtask

   // One full shift clock period, judged after the rise and after the fall
   task automatic step(input logic b);
      logic s6;
      s6 = chain[6];
      host_model_inst.shift_bit(b);
      chain = {chain[6:0], b};
      if (host_pins.transfer_strobe) begin
         latch = chain;
      end
      chk8(par_bus, exp_bus());
      chk1(serial_pins.rise_serial_output, s6);
      chk1(serial_pins.fall_serial_output, fall_exp);
      host_model_inst.fall_edge();
      fall_exp = s6;
      // A slow-edge cascade reads the fall output, a fast-edge one the rise output: same bit
      chk1(serial_pins.fall_serial_output, fall_exp);
      chk1(serial_pins.rise_serial_output, s6);
      chk8(par_bus, exp_bus());
      if (host_pins.transfer_strobe) begin
         q.push_back(chain);
      end
   endtask

   task automatic pop_word(input logic [7:0] exp);
      int n;
      n = 0;
      while (word_valid !== 1'b1 && n < 50) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (word_valid !== 1'b1) begin
         failures++;
         end_sim();
      end
      chk8(word_data, exp);
      word_ready = 1'b1;
      @(posedge clk);
      #1;
      word_ready = 1'b0;
      // Let an edge pass so a following call never raises ready in the same step
      @(posedge clk);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic test_reset();
      chk1(par_pins.enable_n, 1'b1);
      chk1(serial_pins.rise_serial_output, 1'b0);
      chk1(serial_pins.fall_serial_output, 1'b0);
      chk1(word_valid, 1'b0);
      chk1(shift_ready, 1'b1);
      $display("test_reset done");
   endtask

   task automatic test_transparent();
      logic [7:0] pat;
      pat = 8'hA5;
      ctl(1'b1, 1'b1);
      for (int i = 7; i >= 0; i--) begin
         step(pat[i]);
      end
      chk8(par_bus, 8'hA5);
      $display("test_transparent done");
   endtask

   // Strobe low freezes the parallel outputs, raising it alone copies the chain
   task automatic test_hold();
      ctl(1'b0, 1'b1);
      step(1'b1);
      step(1'b1);
      step(1'b0);
      ctl(1'b1, 1'b1);
      $display("test_hold done");
   endtask

   task automatic test_oe();
      ctl(1'b1, 1'b0);
      step(1'b1);
      ctl(1'b0, 1'b0);
      ctl(1'b0, 1'b1);
      $display("test_oe done");
   endtask

   // Receiver stalls while two words go in, then drains them in order
   task automatic test_stream();
      word_ready = 1'b0;
      q.delete();
      ctl(1'b1, 1'b1);
      step(1'b0);
      step(1'b1);
      chk1(shift_ready, 1'b0);
      pop_word(q[0]);
      pop_word(q[1]);
      chk1(word_valid, 1'b0);
      chk1(shift_ready, 1'b1);
      $display("test_stream done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      rst = 1'b1;
      word_ready = 1'b1;
      failures = 0;
      compares = 0;
      chain = '0;
      latch = '0;
      fall_exp = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      rst = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      test_reset();
      test_transparent();
      test_hold();
      test_oe();
      test_stream();
      end_sim();
   end
endmodule
